/* verilog/pwm_reload_defs.vh */
// Register map, field positions, reset values and timing counts of the PWM reload block.
`ifndef PWM_RELOAD_DEFS_VH
`define PWM_RELOAD_DEFS_VH
// Register indexes; the byte address on the bus is four times the index.
`define IDX_ENABLE_CONTROL 8'h20
`define IDX_FREQ_CONTROL 8'h31
`define IDX_GEN_CONFIG 8'h32
`define IDX_MODULUS 8'h34
`define IDX_PULSE_WIDTH 8'h36
`define IDX_IRQ_STATUS 8'h38
`define IDX_IRQ_CLEAR 8'h39
`define IDX_IRQ_ENABLE 8'h3a
// Enable control fields.
`define BIT_GEN_ENABLE 7
`define BIT_LOAD_OKAY 1
`define BIT_RELOAD_IRQ_EN 0
// Frequency control fields.
`define FLD_RELOAD_FREQ_HI 7
`define FLD_RELOAD_FREQ_LO 4
`define BIT_HALF_CYCLE 3
`define FLD_PRESCALER_HI 2
`define FLD_PRESCALER_LO 1
`define BIT_RELOAD_FLAG 0
// Generator configuration fields.
`define BIT_MULTI_TIMEBASE 0
`define BIT_CENTER_ALIGN 1
`define BIT_OVERRIDE_EN 2
`define BIT_OVERRIDE_LEVEL 3
// Reset values.
`define RST_FREQ_FIELD 4'h0
`define RST_PRESCALER 2'h0
`define RST_MODULUS 15'h0000
`define RST_PULSE_WIDTH 15'h0000
// Clock cycles between the internal waveform and the pad.
`define PAD_DELAY_CYCLES 2
`endif

/* verilog/pwm_reload_frequency_control.v */
// PWM generator with buffered reload, reload frequency control and AHB-Lite registers.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "pwm_reload_defs.vh"

module pwm_reload_frequency_control #(
    parameter ADDR_W = 12,
    parameter CNT_W = 15
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    output wire irq,
    output reg pwm_out
);

    // Register index from a byte address; misaligned addresses never match.
    function [7:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            if (addr[1:0] != 2'h0 || addr[ADDR_W-1:10] != {(ADDR_W-10){1'b0}}) begin
                reg_index = 8'hff;
            end else begin
                reg_index = addr[9:2];
            end
        end
    endfunction

    // Prescaler divide mask: 1, 2, 4 or 8 bus clocks per count.
    function [2:0] presc_mask;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: presc_mask = 3'h0;
                2'h1: presc_mask = 3'h1;
                2'h2: presc_mask = 3'h3;
                default: presc_mask = 3'h7;
            endcase
        end
    endfunction

    // Bus state.
    reg wr_pend;
    reg [7:0] wr_idx;
    wire addr_take;
    wire [7:0] a_idx;

    // Software-visible state.
    reg gen_enable;
    reg load_okay;
    reg load_okay_armed;
    reg reload_irq_en;
    reg [3:0] freq_buf;
    reg half_cycle;
    reg [1:0] presc_buf;
    reg reload_flag;
    reg flag_armed;
    reg multi_timebase;
    reg center_align;
    reg override_en;
    reg override_level;
    reg [CNT_W-1:0] mod_buf;
    reg [CNT_W-1:0] width_buf;

    // Active generator state.
    reg [3:0] freq_act;
    reg [3:0] opp_cnt;
    reg [1:0] presc_act;
    reg [CNT_W-1:0] mod_act;
    reg [CNT_W-1:0] width_act;
    reg [2:0] presc_cnt;
    reg [CNT_W-1:0] cnt;
    reg count_down;
    reg pad_stage;

    reg full_evt;
    reg half_evt;
    wire tick;
    wire opportunity;
    wire reload;
    wire wr_en_ctl;
    wire wr_freq;
    wire flag_clear;
    wire pin_level;
    wire rd_take;
    wire wr_gen_cfg;
    wire wr_modulus;
    wire wr_width;
    wire wr_irq_en;
    wire wr_irq_clear;
    reg [7:0] rd_value;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_take = hsel && hready && htrans[1];
    assign a_idx = reg_index(haddr);

    // Writes land in the data phase, using the address captured one edge before.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'hff;
        end else if (hready) begin
            wr_pend <= addr_take && hwrite;
            wr_idx <= a_idx;
        end
    end

    assign wr_en_ctl = wr_pend && wr_idx == `IDX_ENABLE_CONTROL;
    assign wr_freq = wr_pend && wr_idx == `IDX_FREQ_CONTROL && multi_timebase;
    // One strobe per register keeps the address decode in a single place.
    assign wr_gen_cfg = wr_pend && wr_idx == `IDX_GEN_CONFIG;
    assign wr_modulus = wr_pend && wr_idx == `IDX_MODULUS;
    assign wr_width = wr_pend && wr_idx == `IDX_PULSE_WIDTH;
    assign wr_irq_en = wr_pend && wr_idx == `IDX_IRQ_ENABLE;
    assign wr_irq_clear = wr_pend && wr_idx == `IDX_IRQ_CLEAR;
    assign rd_take = addr_take && !hwrite;

    // Both clearing paths need the arming read and a quiet cycle with no reload.
    assign flag_clear = flag_armed && !reload && (
        (wr_freq && hwdata[`BIT_RELOAD_FLAG]) ||
        (wr_irq_clear && hwdata[0]));

    // Read data is registered in the address phase so it stands through the data phase.
    always @* begin
        rd_value = 8'h00;
        case (a_idx)
            `IDX_ENABLE_CONTROL: begin
                rd_value[`BIT_GEN_ENABLE] = gen_enable;
                rd_value[`BIT_LOAD_OKAY] = load_okay;
                rd_value[`BIT_RELOAD_IRQ_EN] = reload_irq_en;
            end
            `IDX_FREQ_CONTROL: begin
                rd_value[`FLD_RELOAD_FREQ_HI:`FLD_RELOAD_FREQ_LO] = freq_buf;
                rd_value[`BIT_HALF_CYCLE] = half_cycle;
                rd_value[`FLD_PRESCALER_HI:`FLD_PRESCALER_LO] = presc_buf;
                rd_value[`BIT_RELOAD_FLAG] = reload_flag;
            end
            `IDX_GEN_CONFIG: begin
                rd_value[`BIT_MULTI_TIMEBASE] = multi_timebase;
                rd_value[`BIT_CENTER_ALIGN] = center_align;
                rd_value[`BIT_OVERRIDE_EN] = override_en;
                rd_value[`BIT_OVERRIDE_LEVEL] = override_level;
            end
            `IDX_IRQ_STATUS: rd_value[0] = reload_flag;
            `IDX_IRQ_ENABLE: rd_value[0] = reload_irq_en;
            default: rd_value = 8'h00;
        endcase
    end

    // Writes leave hrdata alone, so a master may pick up read data late.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            if (a_idx == `IDX_MODULUS) begin
                hrdata <= {{(32-CNT_W){1'b0}}, mod_buf};
            end else if (a_idx == `IDX_PULSE_WIDTH) begin
                hrdata <= {{(32-CNT_W){1'b0}}, width_buf};
            end else begin
                hrdata <= {24'h000000, rd_value};
            end
        end
    end

    // Control and buffer registers.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_enable <= 1'b0;
            reload_irq_en <= 1'b0;
            freq_buf <= `RST_FREQ_FIELD;
            half_cycle <= 1'b0;
            presc_buf <= `RST_PRESCALER;
            multi_timebase <= 1'b0;
            center_align <= 1'b0;
            override_en <= 1'b0;
            override_level <= 1'b0;
            mod_buf <= `RST_MODULUS;
            width_buf <= `RST_PULSE_WIDTH;
        end else begin
            // Two addresses reach one enable flop; the enable control write wins.
            if (wr_en_ctl) begin
                gen_enable <= hwdata[`BIT_GEN_ENABLE];
                reload_irq_en <= hwdata[`BIT_RELOAD_IRQ_EN];
            end else if (wr_irq_en) begin
                reload_irq_en <= hwdata[0];
            end
            if (wr_freq) begin
                freq_buf <= hwdata[`FLD_RELOAD_FREQ_HI:`FLD_RELOAD_FREQ_LO];
                half_cycle <= hwdata[`BIT_HALF_CYCLE];
                presc_buf <= hwdata[`FLD_PRESCALER_HI:`FLD_PRESCALER_LO];
            end
            if (wr_gen_cfg) begin
                multi_timebase <= hwdata[`BIT_MULTI_TIMEBASE];
                center_align <= hwdata[`BIT_CENTER_ALIGN];
                override_en <= hwdata[`BIT_OVERRIDE_EN];
                override_level <= hwdata[`BIT_OVERRIDE_LEVEL];
            end
            if (wr_modulus) begin
                mod_buf <= hwdata[CNT_W-1:0];
            end
            if (wr_width) begin
                width_buf <= hwdata[CNT_W-1:0];
            end
        end
    end

    // Load okay: a read that sees it clear arms the set; a write of zero
    // always clears. A write in the same cycle as the automatic clear wins,
    // so software never loses a set it just made.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_okay <= 1'b0;
            load_okay_armed <= 1'b0;
        end else begin
            if (rd_take && a_idx == `IDX_ENABLE_CONTROL) begin
                load_okay_armed <= !load_okay;
            end else if (wr_en_ctl) begin
                load_okay_armed <= 1'b0;
            end
            if (wr_en_ctl && !hwdata[`BIT_LOAD_OKAY]) begin
                load_okay <= 1'b0;
            end else if (wr_en_ctl && load_okay_armed) begin
                load_okay <= 1'b1;
            end else if (reload && load_okay) begin
                load_okay <= 1'b0;
            end
        end
    end

    // Reload flag with its arming read; a new reload disarms a pending clear.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_flag <= 1'b0;
            flag_armed <= 1'b0;
        end else begin
            if (reload) begin
                reload_flag <= 1'b1;
            end else if (flag_clear) begin
                reload_flag <= 1'b0;
            end
            if (reload) begin
                flag_armed <= 1'b0;
            end else if (rd_take && reload_flag &&
                         (a_idx == `IDX_FREQ_CONTROL || a_idx == `IDX_IRQ_STATUS)) begin
                flag_armed <= 1'b1;
            end else if (flag_clear) begin
                flag_armed <= 1'b0;
            end
        end
    end

    assign irq = reload_flag && reload_irq_en;

    // Counter: edge-aligned wraps at the modulus, center-aligned runs up then down.
    assign tick = gen_enable && presc_cnt == presc_mask(presc_act);

    always @* begin
        full_evt = 1'b0;
        half_evt = 1'b0;
        if (tick) begin
            if (!center_align) begin
                full_evt = cnt + 1'b1 >= mod_act;
            end else if (!count_down) begin
                // The half point fires on the tick that reaches the top, as the full point
                // fires on the tick that reaches zero, so both halves last mod ticks.
                half_evt = cnt + 1'b1 >= mod_act;
            end else begin
                full_evt = cnt <= {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // The rate counter counts opportunities; a half point counts as one of them only when half_cycle is set.
    assign opportunity = full_evt || (half_evt && center_align && half_cycle);
    assign reload = opportunity && opp_cnt == freq_act;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_cnt <= 3'h0;
            cnt <= {CNT_W{1'b0}};
            count_down <= 1'b0;
        end else if (!gen_enable) begin
            presc_cnt <= 3'h0;
            cnt <= {CNT_W{1'b0}};
            count_down <= 1'b0;
        end else begin
            presc_cnt <= tick ? 3'h0 : presc_cnt + 3'h1;
            if (tick) begin
                if (full_evt) begin
                    cnt <= {CNT_W{1'b0}};
                    count_down <= 1'b0;
                end else if (half_evt) begin
                    cnt <= cnt + 1'b1;
                    count_down <= 1'b1;
                end else if (count_down) begin
                    cnt <= cnt - 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

    // Reload frequency and buffered loads.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opp_cnt <= 4'h0;
            freq_act <= `RST_FREQ_FIELD;
            presc_act <= `RST_PRESCALER;
            mod_act <= `RST_MODULUS;
            width_act <= `RST_PULSE_WIDTH;
        end else begin
            // The rate is copied at every reload, loaded or not, so a new rate
            // never cuts the load cycle in progress short.
            if (reload) begin
                opp_cnt <= 4'h0;
                freq_act <= freq_buf;
            end else if (opportunity) begin
                opp_cnt <= opp_cnt + 4'h1;
            end
            if (reload && load_okay) begin
                presc_act <= presc_buf;
                mod_act <= mod_buf;
                width_act <= width_buf;
            end
        end
    end

    // Pin level, then two stages standing in for dead-time insertion.
    // The dead-time logic itself is not modelled, only its latency.
    assign pin_level = gen_enable ? (cnt < width_act) : (override_en && override_level);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_stage <= 1'b0;
            pwm_out <= 1'b0;
        end else begin
            pad_stage <= pin_level;
            pwm_out <= pad_stage;
        end
    end

endmodule // pwm_reload_frequency_control

/* verification/power_stage_model.sv */
// Behavioural power stage that integrates the pad waveform as a count of high cycles.
`timescale 1ns/1ps
module power_stage_model (
    input wire hclk,
    input wire hresetn,
    input wire pwm_out,
    output int high_cycles
);
    // Only a driven high counts, so an unknown pad level shows up as a short count.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_cycles <= 0;
        end else if (pwm_out === 1'b1) begin
            high_cycles <= high_cycles + 1;
        end
    end
endmodule // power_stage_model

/* verification/pwm_reload_checker.sv */
// Concurrent checks on the ports of the PWM reload block.
`timescale 1ns/1ps
module pwm_reload_checker #(
    parameter ADDR_W = 12
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire irq,
    input wire pwm_out
);
    logic wr_dphase;
    wire take = hsel && hready && htrans[1];
    wire [7:0] idx = haddr[9:2];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dphase <= 1'b0;
        end else begin
            wr_dphase <= take && hwrite;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence read_of(logic [7:0] r);
        take && !hwrite && idx == r;
    endsequence
    ready_always_a: assert property (hreadyout)
        else $error("hreadyout dropped");
    okay_resp_a: assert property (!hresp)
        else $error("hresp not okay");
    rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("hrdata changed without a read");
    irq_drop_a: assert property ($fell(irq) |-> $past(wr_dphase))
        else $error("irq fell without a register write");
    status_irq_a: assert property (read_of(8'h38) ##0 irq |=> hrdata[0])
        else $error("status flag low while irq high");
    irq_gate_a: assert property (read_of(8'h3a) ##0 !wr_dphase ##1 !hrdata[0] |-> !irq)
        else $error("irq high with enable clear");
    freq_width_a: assert property (read_of(8'h31) |=> hrdata[31:8] == 24'h000000)
        else $error("frequency control upper bits set");
    enable_gaps_a: assert property (read_of(8'h20) |=> hrdata[6:2] == 5'h00)
        else $error("enable control reserved bits set");
    unmapped_zero_a: assert property (read_of(8'h10) |=> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule // pwm_reload_checker

bind pwm_reload_frequency_control pwm_reload_checker #(.ADDR_W(ADDR_W)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .pwm_out(pwm_out));

/* verification/pwm_reload_frequency_control_bench.sv */
// Self-checking bench for the PWM reload block over its AHB-Lite registers.
`timescale 1ns/1ps
`include "pwm_reload_defs.vh"
module pwm_reload_frequency_control_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    wire hready;
    wire hresp;
    wire [31:0] hrdata;
    wire irq;
    wire pwm_out;
    int high_cycles;
    int h0;
    int mismatches = 0;
    int comparisons = 0;
    time last_t = 0;
    pwm_reload_frequency_control dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .pwm_out(pwm_out));
    power_stage_model load_u (.hclk(hclk), .hresetn(hresetn), .pwm_out(pwm_out),
        .high_cycles(high_cycles));
    initial begin
        forever #10 hclk = ~hclk;
    end
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {2'b00, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        check(what, exp, rd);
    endtask
    // Clears the flag, waits for the next reload and, when cyc is above zero, checks the spacing from the last one.
    task automatic rel(input int cyc, input string what);
        int n;
        n = 0;
        xfer(1'b0, `IDX_IRQ_STATUS, 32'h0);
        wr(`IDX_IRQ_CLEAR, 32'h1);
        @(posedge hclk);
        check("irq withdrawn", 32'h0, {31'h0, irq});
        while (irq !== 1'b1 && n < 5000) begin
            @(posedge hclk);
            n++;
        end
        check("reload seen", 32'h1, {31'h0, irq});
        if (cyc > 0) check(what, 32'(cyc), 32'(($time - last_t) / 20));
        last_t = $time;
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("enable ctl", `IDX_ENABLE_CONTROL, 32'h0);
        rchk("irq enable", `IDX_IRQ_ENABLE, 32'h0);
        wr(8'h10, 32'hff);
        rchk("unmapped", 8'h10, 32'h0);
        wr(`IDX_FREQ_CONTROL, 32'hf0);
        rchk("freq gated", `IDX_FREQ_CONTROL, 32'h0);
        wr(`IDX_GEN_CONFIG, 32'h1);
        wr(`IDX_FREQ_CONTROL, 32'hf0);
        rchk("freq written", `IDX_FREQ_CONTROL, 32'hf0);
        wr(`IDX_MODULUS, 32'd100);
        wr(`IDX_PULSE_WIDTH, 32'd50);
        xfer(1'b0, `IDX_ENABLE_CONTROL, 32'h0);
        wr(`IDX_ENABLE_CONTROL, 32'h02);
        rchk("load okay set", `IDX_ENABLE_CONTROL, 32'h02);
        wr(`IDX_ENABLE_CONTROL, 32'h82);
        do xfer(1'b0, `IDX_IRQ_STATUS, 32'h0); while (rd[0] !== 1'b1);
        rchk("load okay cleared", `IDX_ENABLE_CONTROL, 32'h80);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(`IDX_IRQ_ENABLE, 32'h1);
        @(posedge hclk);
        check("irq raised", 32'h1, {31'h0, irq});
        rel(0, "sync");
        rel(1600, "rate code 15");
        wr(`IDX_FREQ_CONTROL, 32'h10);
        rchk("freq buffered", `IDX_FREQ_CONTROL, 32'h11);
        rel(1600, "old rate kept");
        rel(200, "rate code 1");
        xfer(1'b0, `IDX_IRQ_STATUS, 32'h0);
        repeat (210) @(posedge hclk);
        wr(`IDX_IRQ_CLEAR, 32'h1);
        @(posedge hclk);
        check("flag kept", 32'h1, {31'h0, irq});
        rel(400, "after kept flag");
        wr(`IDX_MODULUS, 32'd50);
        wr(`IDX_PULSE_WIDTH, 32'd20);
        rel(200, "no load");
        xfer(1'b0, `IDX_ENABLE_CONTROL, 32'h0);
        wr(`IDX_ENABLE_CONTROL, 32'h83);
        rel(200, "loading reload");
        h0 = high_cycles;
        rel(100, "new modulus");
        check("high cycles", 32'd40, 32'(high_cycles - h0));
        rchk("load okay auto", `IDX_ENABLE_CONTROL, 32'h81);
        wr(`IDX_GEN_CONFIG, 32'h3);
        wr(`IDX_FREQ_CONTROL, 32'h08);
        rel(0, "settle");
        rel(0, "settle");
        rel(50, "half cycle");
        wr(`IDX_FREQ_CONTROL, 32'h0a);
        rchk("presc buffered", `IDX_FREQ_CONTROL, 32'h0b);
        rel(50, "presc held");
        xfer(1'b0, `IDX_ENABLE_CONTROL, 32'h0);
        wr(`IDX_ENABLE_CONTROL, 32'h83);
        rel(50, "presc loading");
        rel(100, "presc active");
        wr(`IDX_ENABLE_CONTROL, 32'h01);
        repeat (4) @(posedge hclk);
        check("pad idle", 32'h0, {31'h0, pwm_out});
        wr(`IDX_GEN_CONFIG, 32'h0d);
        repeat (4) @(posedge hclk);
        check("pad override", 32'h1, {31'h0, pwm_out});
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge hclk);
        mismatches++;
        finish_test();
    end
endmodule // pwm_reload_frequency_control_bench
